// >>> rtl/afpm_pkg.sv
// Constants and types shared by the arrow pair fault monitor files
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package afpm_pkg;
  localparam int NCH = 16;
  localparam int NPAIR = 4;
  localparam int CLK_MHZ = 125;
  localparam int MS_US = 1000;
  localparam int MS_CYCLES = CLK_MHZ * MS_US;
  localparam int BAUD_RATE = 9600;
  localparam int BAUD_CYCLES = CLK_MHZ * 1000000 / BAUD_RATE;
  localparam int FLASH_MAX_MS = 1600;
  localparam int FLASH_MIN_MS = 1400;
  localparam int DUAL_MAX_MS = 500;
  localparam int DUAL_MIN_MS = 200;
  localparam int RED_FAIL_MS = 1000;
  localparam int CLEAR_MIN_MS = 2700;
  localparam int HIST_STEP_MS = 50;
  localparam int HIST_SPAN_MS = 2000;
  localparam int HIST_DEPTH = HIST_SPAN_MS / HIST_STEP_MS + 1;
  localparam int HIST_W = 3 * NCH + 1;
  localparam int LOG_DEPTH = 9;
  localparam int ENTRY_BYTES = 27;
  localparam int ENTRY_W = 8 * ENTRY_BYTES;
  localparam int PHASE_STEP = 2;
  localparam int STD_ARROW_BASE = 8;
  localparam int CMP_GREEN_BASE = 8;
  localparam int CNT_W = 12;

  typedef enum logic [3:0] {
    EV_NONE = 4'h0,
    EV_CONFLICT = 4'h1,
    EV_FLASH = 4'h2,
    EV_REDFAIL = 4'h3,
    EV_DUAL = 4'h4,
    EV_CLEAR = 4'h5,
    EV_RESET = 4'h6,
    EV_CONFIG = 4'h7,
    EV_PREVFLT = 4'h8,
    EV_ACLINE = 4'h9
  } afpm_event_t;

  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_SEND = 2'b01,
    S_WAIT = 2'b10
  } afpm_dump_t;
endpackage

// >>> rtl/afpm_uart_tx.sv
// Serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ps
module afpm_uart_tx #(
  parameter int BAUD = afpm_pkg::BAUD_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic txStart,
  input wire logic [7:0] txByte,
  output logic txBusy,
  output logic txLine
);
  typedef struct packed {
    logic busy;
    logic [9:0] shift;
    logic [3:0] bitCnt;
    logic [14:0] baudCnt;
    logic line;
  } afpm_tx_t;
  afpm_tx_t r, n;

  // Frame shifter
  always_comb
  begin
    n = r;
    if (!r.busy)
    begin
      if (txStart)
      begin
        n.busy = 1'b1;
        n.shift = {1'b1, txByte, 1'b0};
        n.bitCnt = 4'ha;
        n.baudCnt = 15'(BAUD - 1);
      end
    end
    else if (r.baudCnt == 15'h0)
    begin
      n.baudCnt = 15'(BAUD - 1);
      n.shift = {1'b1, r.shift[9:1]};
      n.bitCnt = r.bitCnt - 4'h1;
      n.busy = (r.bitCnt != 4'h1);
    end
    else
      n.baudCnt = r.baudCnt - 15'h1;
    n.line = n.busy ? n.shift[0] : 1'b1;
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      r <= '{busy: 1'b0, shift: 10'h3ff, bitCnt: 4'h0,
             baudCnt: 15'h0, line: 1'b1};
    else
      r <= n;
  end

  assign txBusy = r.busy;
  assign txLine = r.line;
endmodule

// >>> rtl/afpm_uart_rx.sv
// Serial receiver with pin synchroniser and mid-bit sampling
`timescale 1ns/1ps
module afpm_uart_rx #(
  parameter int BAUD = afpm_pkg::BAUD_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic rxLine,
  output logic rxValid,
  output logic [7:0] rxByte
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic busy;
    logic [3:0] bitCnt;
    logic [15:0] baudCnt;
    logic [7:0] shift;
    logic valid;
    logic [7:0] data;
  } afpm_rx_t;
  afpm_rx_t r, n;

  // Start detect and bit sampling
  always_comb
  begin
    n = r;
    n.s1 = rxLine;
    n.s2 = r.s1;
    n.valid = 1'b0;
    if (!r.busy)
    begin
      if (!r.s2)
      begin
        n.busy = 1'b1;
        n.bitCnt = 4'h8;
        n.baudCnt = 16'(BAUD + BAUD / 2 - 1);
      end
    end
    else if (r.baudCnt != 16'h0)
      n.baudCnt = r.baudCnt - 16'h1;
    else if (r.bitCnt != 4'h0)
    begin
      n.shift = {r.s2, r.shift[7:1]};
      n.bitCnt = r.bitCnt - 4'h1;
      n.baudCnt = 16'(BAUD - 1);
    end
    else
    begin
      n.busy = 1'b0;
      n.valid = r.s2;
      n.data = r.s2 ? r.shift : r.data;
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      r <= '{s1: 1'b1, s2: 1'b1, busy: 1'b0, bitCnt: 4'h0,
             baudCnt: 16'h0, shift: 8'h0, valid: 1'b0, data: 8'h0};
    else
      r <= n;
  end

  assign rxValid = r.valid;
  assign rxByte = r.data;
endmodule

// >>> rtl/afpm_monitor.sv
// Arrow pair fault checks, event log, sequence history, log readout
`timescale 1ns/1ps
module afpm_monitor #(
  parameter int MS_CYCLES = afpm_pkg::MS_CYCLES,
  parameter int BAUD_CYCLES = afpm_pkg::BAUD_CYCLES
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [15:0] chRedOn,
  input wire logic [15:0] chYellowOn,
  input wire logic [15:0] chGreenOn,
  input wire logic redEnable,
  input wire logic [3:0] pairFlashEnable,
  input wire logic compactArrowMapping,
  input wire logic flashRateJumper,
  input wire logic flashRateSwitchOn,
  input wire logic [3:0][15:0] permConflictMap,
  input wire logic [3:0][15:0] protConflictMap,
  input wire logic frontReset,
  input wire logic remoteReset,
  input wire logic cfgChange,
  input wire logic prevFault,
  input wire logic acLineLow,
  input wire logic [31:0] timeStamp,
  input wire logic [127:0] rmsLevels,
  input wire logic [5:0] histIdx,
  output logic [48:0] histData,
  output logic [3:0] pairFaultConflict,
  output logic [3:0] pairFaultFlash,
  output logic [3:0] pairFaultRed,
  output logic [3:0] pairFaultDual,
  output logic [3:0] pairFaultClear,
  output logic forceFlash,
  input wire logic rxData,
  input wire logic dtrIn,
  input wire logic ctsIn,
  output logic txData,
  output logic dcdOut,
  output logic dsrOut,
  output logic rtsOut
);
  localparam int PIN_W = 191;
  localparam logic [11:0] FLASH_MAX = 12'(afpm_pkg::FLASH_MAX_MS);
  localparam logic [11:0] FLASH_MIN = 12'(afpm_pkg::FLASH_MIN_MS);
  localparam logic [11:0] DUAL_MAX = 12'(afpm_pkg::DUAL_MAX_MS);
  localparam logic [11:0] DUAL_MIN = 12'(afpm_pkg::DUAL_MIN_MS);
  localparam logic [11:0] RED_MAX = 12'(afpm_pkg::RED_FAIL_MS);
  localparam logic [11:0] CLEAR_MIN = 12'(afpm_pkg::CLEAR_MIN_MS);
  localparam logic [5:0] HIST_LAST = 6'(afpm_pkg::HIST_STEP_MS - 1);
  localparam logic [3:0] LOG_LAST = 4'(afpm_pkg::LOG_DEPTH - 1);
  localparam logic [4:0] BYTE_LAST = 5'(afpm_pkg::ENTRY_BYTES - 1);
  // Longest wait for the transmitter: one frame plus handover slack
  localparam logic [17:0] SEND_LIMIT = 18'(10 * BAUD_CYCLES + 2);

  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [1:0] rstSeen;
    logic [2:0] evPrev;
    logic [16:0] msCnt;
    logic [5:0] histTick;
    logic [3:0][11:0] flashCnt;
    logic [3:0][11:0] dualCnt;
    logic [3:0][11:0] redCnt;
    logic [3:0][11:0] yelCnt;
    logic [3:0] armed;
    logic [3:0] protLast;
    logic [3:0] yelPrev;
    logic [3:0] fConf;
    logic [3:0] fFlash;
    logic [3:0] fRed;
    logic [3:0] fDual;
    logic [3:0] fClr;
    logic [40:0][48:0] hist;
    logic [48:0] histOut;
    logic [8:0][215:0] logMem;
    logic [3:0] logWr;
    afpm_pkg::afpm_dump_t dump;
    logic [3:0] dumpEntry;
    logic [4:0] dumpByte;
    logic txStart;
    logic [7:0] txByte;
    logic [17:0] sendWait;
  } afpm_state_t;
  afpm_state_t r, n;

  logic [PIN_W-1:0] pinRaw;
  logic [15:0] qRed, qYel, qGrn, chActive;
  logic qRedEn, qCompact, qJumper, qSwitchOn;
  logic qFront, qRemote, qCfg, qPrev, qAc, qDtr, qCts;
  logic [3:0] qPairEn;
  logic [3:0][15:0] qPerm, qProt;
  logic [3:0] redArrowInput, solidYellowArrowInput;
  logic [3:0] flashingLeftArrow, greenArrowInput;
  logic [3:0] confHit, flashHit, redHit, dualHit, clrHit;
  logic msTick, histStep, rstPulse, flashRateEn;
  logic rxValid, txBusy;
  logic [7:0] rxByte;
  afpm_pkg::afpm_event_t evType;
  logic [3:0] evPairs;

  //----------------------------------------------------------------------
  // Pin synchronisers and field unpacking
  //----------------------------------------------------------------------
  assign pinRaw = {chRedOn, chYellowOn, chGreenOn, redEnable,
                   pairFlashEnable, compactArrowMapping, flashRateJumper,
                   flashRateSwitchOn, permConflictMap, protConflictMap,
                   frontReset, remoteReset, cfgChange, prevFault, acLineLow,
                   dtrIn, ctsIn};
  assign {qRed, qYel, qGrn, qRedEn, qPairEn, qCompact, qJumper, qSwitchOn,
          qPerm, qProt, qFront, qRemote, qCfg, qPrev, qAc, qDtr,
          qCts} = r.s2;
  assign chActive = qGrn | qYel;
  assign flashRateEn = qJumper | ~qSwitchOn;
  assign rstPulse = (qFront & ~r.rstSeen[1]) | (qRemote & ~r.rstSeen[0]);
  assign msTick = (r.msCnt == 17'(MS_CYCLES - 1));
  assign histStep = msTick && (r.histTick == HIST_LAST);

  //----------------------------------------------------------------------
  // Arrow channel mapping per pair
  //----------------------------------------------------------------------
  // mapping selector
  for (genvar p = 0; p < afpm_pkg::NPAIR; p++)
  begin : g_map
    localparam int PCH = afpm_pkg::PHASE_STEP * p;
    localparam int AH = afpm_pkg::STD_ARROW_BASE + p;
    localparam int CG = afpm_pkg::CMP_GREEN_BASE + p / 2;
    logic cmpGreen;
    assign cmpGreen = (p % 2 == 1) ? qYel[CG] : qGrn[CG];
    assign redArrowInput[p] = qCompact ? qRed[PCH] : qRed[AH];
    assign solidYellowArrowInput[p] = qCompact ? qYel[PCH] : qYel[AH];
    assign flashingLeftArrow[p] = qCompact ? qGrn[PCH] : qGrn[AH];
    assign greenArrowInput[p] = qCompact ? cmpGreen : qGrn[PCH];
  end

  // Saturating millisecond step
  function automatic logic [11:0] satStep(input logic [11:0] cnt,
                                          input logic [11:0] lim,
                                          input logic tick);
    satStep = (cnt >= lim) ? lim : cnt + {11'h0, tick};
  endfunction

  //----------------------------------------------------------------------
  // Next-state logic
  //----------------------------------------------------------------------
  always_comb
  begin
    logic [2:0] onCnt;
    logic ra, ya, fa, ga;
    logic [3:0] logIdx;
    logic [215:0] entryBits;
    logic [7:0] bytePos;
    logic [4:0] idxSum;
    onCnt = 3'h0;
    logIdx = 4'h0;
    entryBits = '0;
    bytePos = 8'h0;
    idxSum = 5'h0;
    ra = 1'b0;
    ya = 1'b0;
    fa = 1'b0;
    ga = 1'b0;
    n = r;
    n.s1 = pinRaw;
    n.s2 = r.s1;
    n.rstSeen = {qFront, qRemote};
    n.evPrev = {qCfg, qPrev, qAc};
    n.msCnt = msTick ? 17'h0 : r.msCnt + 17'h1;
    if (msTick)
      n.histTick = histStep ? 6'h0 : r.histTick + 6'h1;
    n.txStart = 1'b0;
    // Cycles a readout byte has waited with clear to send
    n.sendWait = (r.dump == afpm_pkg::S_SEND && qCts)
                 ? r.sendWait + 18'h1 : 18'h0;
    confHit = 4'h0;
    flashHit = 4'h0;
    redHit = 4'h0;
    dualHit = 4'h0;
    clrHit = 4'h0;

    // Per-pair checks
    for (int p = 0; p < afpm_pkg::NPAIR; p++)
    begin
      ra = redArrowInput[p];
      ya = solidYellowArrowInput[p];
      fa = flashingLeftArrow[p];
      ga = greenArrowInput[p];
      onCnt = {2'h0, ra} + {2'h0, ya} + {2'h0, fa} + {2'h0, ga};
      n.yelPrev[p] = ya;
      if (!qPairEn[p])
      begin
        n.flashCnt[p] = 12'h0;
        n.dualCnt[p] = 12'h0;
        n.redCnt[p] = 12'h0;
        n.yelCnt[p] = 12'h0;
        n.armed[p] = 1'b0;
      end
      else
      begin
        if (ga)
          n.protLast[p] = 1'b1;
        else if (fa)
          n.protLast[p] = 1'b0;
        if (ya)
        begin
          if (r.protLast[p])
            confHit[p] = |(chActive & qProt[p]);
          else
            confHit[p] = |(chActive & qPerm[p]);
        end
        if (fa && flashRateEn)
          n.flashCnt[p] = satStep(r.flashCnt[p], FLASH_MAX, msTick);
        else
          n.flashCnt[p] = 12'h0;
        flashHit[p] = (r.flashCnt[p] == FLASH_MAX);
        if (onCnt >= 3'h2 && qRedEn)
          n.dualCnt[p] = satStep(r.dualCnt[p], DUAL_MAX, msTick);
        else
          n.dualCnt[p] = 12'h0;
        dualHit[p] = (r.dualCnt[p] == DUAL_MAX);
        if (onCnt == 3'h0 && qRedEn)
          n.redCnt[p] = satStep(r.redCnt[p], RED_MAX, msTick);
        else
          n.redCnt[p] = 12'h0;
        redHit[p] = (r.redCnt[p] == RED_MAX);
        // arm while either arrow interval is on
        if (ga || fa)
        begin
          n.armed[p] = 1'b1;
          n.yelCnt[p] = 12'h0;
        end
        else if (r.armed[p])
        begin
          if (ya)
            n.yelCnt[p] = satStep(r.yelCnt[p], CLEAR_MIN, msTick);
          else if (r.yelPrev[p])
          begin
            clrHit[p] = (r.yelCnt[p] < CLEAR_MIN);
            n.armed[p] = 1'b0;
          end
          else if (ra)
          begin
            clrHit[p] = 1'b1;
            n.armed[p] = 1'b0;
          end
        end
      end
    end

    // latch until reset, set beats clear
    n.fConf = (rstPulse ? 4'h0 : r.fConf) | confHit;
    n.fFlash = (rstPulse ? 4'h0 : r.fFlash) | flashHit;
    n.fRed = (rstPulse ? 4'h0 : r.fRed) | redHit;
    n.fDual = (rstPulse ? 4'h0 : r.fDual) | dualHit;
    n.fClr = (rstPulse ? 4'h0 : r.fClr) | clrHit;

    evPairs = 4'h0;
    if (|(confHit & ~r.fConf))
    begin
      evType = afpm_pkg::EV_CONFLICT;
      evPairs = confHit & ~r.fConf;
    end
    else if (|(flashHit & ~r.fFlash))
    begin
      evType = afpm_pkg::EV_FLASH;
      evPairs = flashHit & ~r.fFlash;
    end
    else if (|(redHit & ~r.fRed))
    begin
      evType = afpm_pkg::EV_REDFAIL;
      evPairs = redHit & ~r.fRed;
    end
    else if (|(dualHit & ~r.fDual))
    begin
      evType = afpm_pkg::EV_DUAL;
      evPairs = dualHit & ~r.fDual;
    end
    else if (|(clrHit & ~r.fClr))
    begin
      evType = afpm_pkg::EV_CLEAR;
      evPairs = clrHit & ~r.fClr;
    end
    else if (rstPulse)
      evType = afpm_pkg::EV_RESET;
    else if (qCfg && !r.evPrev[2])
      evType = afpm_pkg::EV_CONFIG;
    else if (qPrev && !r.evPrev[1])
      evType = afpm_pkg::EV_PREVFLT;
    else if (qAc && !r.evPrev[0])
      evType = afpm_pkg::EV_ACLINE;
    else
      evType = afpm_pkg::EV_NONE;

    if (evType != afpm_pkg::EV_NONE)
    begin
      n.logMem[r.logWr] = {timeStamp, evType, evPairs, qRed, qYel, qGrn,
                           rmsLevels};
      n.logWr = (r.logWr == LOG_LAST) ? 4'h0 : r.logWr + 4'h1;
    end

    // history frozen once a fault holds
    if (histStep && !forceFlash)
      n.hist = {r.hist[39:0], {qRedEn, qRed, qYel, qGrn}};
    n.histOut = (histIdx <= 6'(afpm_pkg::HIST_DEPTH - 1))
                ? r.hist[histIdx] : 49'h0;

    // log readout, oldest entry first
    // Wrap in five bits so a full ring cannot overflow the sum
    idxSum = {1'b0, r.logWr} + {1'b0, r.dumpEntry};
    if (idxSum > {1'b0, LOG_LAST})
      idxSum = idxSum - 5'(afpm_pkg::LOG_DEPTH);
    logIdx = idxSum[3:0];
    entryBits = r.logMem[logIdx];
    bytePos = 8'(8 * (afpm_pkg::ENTRY_BYTES - 1 - int'(r.dumpByte)));
    unique case (r.dump)
      afpm_pkg::S_IDLE:
      begin
        if (rxValid && qDtr)
        begin
          n.dumpEntry = 4'h0;
          n.dumpByte = 5'h0;
          n.dump = afpm_pkg::S_SEND;
        end
      end
      afpm_pkg::S_SEND:
      begin
        if (!txBusy && qCts)
        begin
          n.txStart = 1'b1;
          n.txByte = entryBits[bytePos +: 8];
          n.dump = afpm_pkg::S_WAIT;
          n.dumpByte = (r.dumpByte == BYTE_LAST) ? 5'h0 : r.dumpByte + 5'h1;
          if (r.dumpByte == BYTE_LAST)
            n.dumpEntry = r.dumpEntry + 4'h1;
        end
      end
      afpm_pkg::S_WAIT:
      begin
        if (txBusy)
          n.dump = (r.dumpEntry > LOG_LAST) ? afpm_pkg::S_IDLE
                                           : afpm_pkg::S_SEND;
      end
      default:
        n.dump = afpm_pkg::S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (srst)
      r <= '0;
    else
      r <= n;
  end

  //----------------------------------------------------------------------
  // Serial link, data communications equipment side
  //----------------------------------------------------------------------
  afpm_uart_rx #(.BAUD(BAUD_CYCLES)) u_rx (
    .core_clk(core_clk),
    .srst(srst),
    .rxLine(rxData),
    .rxValid(rxValid),
    .rxByte(rxByte)
  );

  afpm_uart_tx #(.BAUD(BAUD_CYCLES)) u_tx (
    .core_clk(core_clk),
    .srst(srst),
    .txStart(r.txStart),
    .txByte(r.txByte),
    .txBusy(txBusy),
    .txLine(txData)
  );

  // Outputs
  assign dcdOut = 1'b1;
  assign dsrOut = 1'b1;
  assign rtsOut = (r.dump == afpm_pkg::S_IDLE);
  assign histData = r.histOut;
  assign pairFaultConflict = r.fConf;
  assign pairFaultFlash = r.fFlash;
  assign pairFaultRed = r.fRed;
  assign pairFaultDual = r.fDual;
  assign pairFaultClear = r.fClr;
  assign forceFlash = |{r.fConf, r.fFlash, r.fRed, r.fDual, r.fClr};

  //----------------------------------------------------------------------
  // Assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  sequence s_dump_req;
    rxValid && qDtr && r.dump == afpm_pkg::S_IDLE;
  endsequence
  sequence s_byte_go;
    r.txStart ##1 txBusy;
  endsequence

  a_flash_trip: assert property (
    $rose(r.fFlash[0]) |-> $past(r.flashCnt[0]) == FLASH_MAX)
    else $error("flash fault without full on-time");
  a_flash_quiet: assert property (
    !r.fFlash[0] && !flashHit[0] && r.flashCnt[0] < FLASH_MIN
    |=> !r.fFlash[0])
    else $error("flash fault before minimum on-time");
  a_fault_hold: assert property (
    $fell(forceFlash) |-> $past(rstPulse))
    else $error("fault dropped without reset");
  a_rate_enable: assert property (
    !flashRateEn |=> r.flashCnt[0] == 12'h0 && r.flashCnt[3] == 12'h0)
    else $error("flash timing while disabled");
  a_pair_gate: assert property (
    !qPairEn[0] |=> r.dualCnt[0] == 12'h0 && r.redCnt[0] == 12'h0)
    else $error("checks running on disabled pair");
  a_dual_persist: assert property (
    $rose(r.fDual[2]) |-> $past(r.dualCnt[2]) >= DUAL_MIN)
    else $error("dual fault too early");
  a_red_dark: assert property (
    $rose(r.fRed[0]) |-> $past(r.redCnt[0]) == RED_MAX)
    else $error("red failure without dark time");
  a_conf_latch: assert property (
    confHit[2] |=> r.fConf[2] [*2] or rstPulse)
    else $error("clearance conflict not latched");
  a_clear_short: assert property (
    $rose(r.fClr[2]) |-> $past(r.yelCnt[2]) < CLEAR_MIN)
    else $error("clearance fault with full yellow");
  a_hist_freeze: assert property (
    forceFlash |=> r.hist == $past(r.hist))
    else $error("history moved after trigger");
  a_dump_start: assert property (
    s_dump_req |=> r.dump == afpm_pkg::S_SEND)
    else $error("readout did not start");
  a_byte_go: assert property (
    r.dump == afpm_pkg::S_SEND && !txBusy && qCts |=> s_byte_go)
    else $error("readout byte not launched");
  a_send_bound: assert property (
    r.sendWait < SEND_LIMIT)
    else $error("readout byte waited too long");
endmodule

// >>> dv/afpm_ctrl_model.sv
// Cabinet controller model on the serial side of the monitor
`timescale 1ns/1ps
module afpm_ctrl_model #(
  parameter int BAUD = 4
) (
  input wire logic core_clk,
  input wire logic txData,
  output logic rxData,
  output logic dtrIn,
  output logic ctsIn
);
  logic [7:0] got [$];

  // Line idles high, terminal ready and clear to send
  initial
  begin
    rxData = 1'b1;
    dtrIn = 1'b1;
    ctsIn = 1'b1;
  end

  always
  begin : rx_byte
    logic [7:0] b;
    @(negedge txData);
    repeat (BAUD / 2) @(posedge core_clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BAUD) @(posedge core_clk);
      b[i] = txData;
    end
    repeat (BAUD) @(posedge core_clk);
    got.push_back(b);
  end

  // Holds or releases clear to send between bytes
  task set_cts(input logic v);
    ctsIn = v;
  endtask

  // Sends one 8N1 byte, low bit first
  task send(input logic [7:0] v);
    logic [9:0] f;
    f = {1'b1, v, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge core_clk);
      rxData = f[i];
      repeat (BAUD - 1) @(negedge core_clk);
    end
  endtask
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the arrow pair fault monitor
`timescale 1ns/1ps
module tb_top;
  localparam int MSC = 10;
  localparam int BDC = 4;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [15:0] red = '0, yel = '0, grn = '0;
  logic redEn = 1'b0, cmp = 1'b0, jmp = 1'b1, swOn = 1'b0;
  logic frontReset = 1'b0, remoteReset = 1'b0, cfgChange = 1'b0;
  logic [3:0] pairEn = 4'h1;
  logic [3:0][15:0] permMap = '0, protMap = '0;
  logic [31:0] timeStamp = '0;
  logic [3:0] fCon, fFla, fRed, fDua, fClr;
  logic [48:0] hist;
  logic forceFlash, txData, rxData, dtrIn, ctsIn, rtsOut;
  int failures = 0;
  int checks_done = 0;

  // Clock and running time word
  always #4 core_clk = ~core_clk;
  always @(negedge core_clk) timeStamp <= timeStamp + 32'h1;

  afpm_monitor #(.MS_CYCLES(MSC), .BAUD_CYCLES(BDC)) dut (
    .core_clk(core_clk), .srst(srst), .chRedOn(red), .chYellowOn(yel),
    .chGreenOn(grn), .redEnable(redEn), .pairFlashEnable(pairEn),
    .compactArrowMapping(cmp), .flashRateJumper(jmp),
    .flashRateSwitchOn(swOn), .permConflictMap(permMap),
    .protConflictMap(protMap), .frontReset(frontReset),
    .remoteReset(remoteReset), .cfgChange(cfgChange), .prevFault(1'b0),
    .acLineLow(1'b0), .timeStamp(timeStamp), .rmsLevels(128'h0),
    .histIdx(6'h0), .histData(hist), .pairFaultConflict(fCon),
    .pairFaultFlash(fFla), .pairFaultRed(fRed), .pairFaultDual(fDua),
    .pairFaultClear(fClr), .forceFlash(forceFlash), .rxData(rxData),
    .dtrIn(dtrIn), .ctsIn(ctsIn), .txData(txData), .dcdOut(),
    .dsrOut(), .rtsOut(rtsOut));

  afpm_ctrl_model #(.BAUD(BDC)) ctl (.core_clk(core_clk),
    .txData(txData), .rxData(rxData), .dtrIn(dtrIn), .ctsIn(ctsIn));

  //--------------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------------
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task ms(input int n);
    repeat (n * MSC) @(negedge core_clk);
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    ms(1);
    s = 1'b0;
    ms(3);
  endtask

  // Darkens the field and clears latched faults
  task clear_all;
    {red, yel, grn, redEn} = '0;
    ms(3);
    pulse(frontReset);
    chk("clean", {fCon | fFla | fRed | fDua | fClr, 3'h0, forceFlash}, 8'h0);
  endtask

  //--------------------------------------------------------------------
  // Scenarios
  //--------------------------------------------------------------------
  task t_flash;
    grn[8] = 1'b1;
    ms(1300);
    chk("flash early", fFla, 8'h0);
    ms(400);
    chk("flash", fFla, 8'h1);
    chk("force", forceFlash, 8'h1);
    grn[8] = 1'b0;
    ms(60);
    chk("flash held", fFla, 8'h1);
    chk("history", hist[15:8], 8'h1);
    pulse(remoteReset);
    chk("flash clear", fFla, 8'h0);
    $display("test flash done");
  endtask

  task t_gates;
    cmp = 1'b1;
    repeat (2)
    begin
      grn[0] = 1'b1;
      ms(900);
      grn[0] = 1'b0;
      ms(10);
    end
    chk("restart", fFla, 8'h0);
    {jmp, swOn, grn[0]} = 3'b011;
    ms(1650);
    chk("flash off", fFla, 8'h0);
    {jmp, swOn, pairEn} = 6'b100000;
    ms(1650);
    chk("pair off", fFla, 8'h0);
    clear_all();
    $display("test gating done");
  endtask

  task t_dual;
    {cmp, pairEn, redEn} = 6'b011111;
    red[10] = 1'b1;
    grn[4] = 1'b1;
    ms(150);
    chk("dual early", fDua, 8'h0);
    ms(450);
    chk("dual", fDua, 8'h4);
    ms(500);
    chk("red fail", fRed, 8'hb);
    clear_all();
    $display("test dual done");
  endtask

  task t_conflict;
    cmp = 1'b1;
    protMap[2][1] = 1'b1;
    grn[9] = 1'b1;
    ms(20);
    grn[9] = 1'b0;
    grn[1] = 1'b1;
    ms(5);
    chk("no conflict", fCon, 8'h0);
    yel[4] = 1'b1;
    ms(3);
    chk("conflict", fCon, 8'h4);
    clear_all();
    // Permissive interval uses only the permissive map
    permMap[2][11] = 1'b1;
    grn[4] = 1'b1;
    ms(5);
    {grn[4], grn[11], yel[4]} = 3'b011;
    ms(3);
    chk("perm conflict", fCon, 8'h4);
    clear_all();
    $display("test conflict done");
  endtask

  task t_log;
    int n;
    pulse(cfgChange);
    ctl.set_cts(1'b0);
    ctl.send(8'h3f);
    n = 0;
    while (rtsOut !== 1'b0 && n < 200)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("dump busy", rtsOut, 8'h0);
    ms(10);
    chk("cts hold", ctl.got.size(), 8'h0);
    ctl.set_cts(1'b1);
    n = 0;
    while (ctl.got.size() < 243 && n < 20000)
    begin
      @(negedge core_clk);
      n++;
    end
    ms(10);
    chk("bytes", ctl.got.size(), 8'd243);
    chk("newest type", ctl.got[220] >> 4, 8'h7);
    chk("dump idle", rtsOut, 8'h1);
    $display("test log done");
  endtask

  // Closing verdict
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog beyond the expected run length
  initial
  begin
    repeat (100000) @(posedge core_clk);
    failures++;
    report_and_stop();
  end

  // Main sequence
  initial
  begin
    repeat (3) @(negedge core_clk);
    srst = 1'b0;
    ms(1);
    t_flash();
    t_gates();
    t_dual();
    t_conflict();
    t_log();
    report_and_stop();
  end
endmodule
